/* hdl/rtc_core.v */
// Battery-backed BCD calendar clock with alarms, wakeup timer, tamper and backup store
`timescale 1ns/10ps
`default_nettype none
`include "rtc_regs.vh"
module rtc_core #(
   parameter [14:0] PRESC = 15'h7FFF
) (
   // Clock and reset
   input  wire        clock_i,
   input  wire        rstn_i,
   // Register port
   input  wire [7:0]  addr_i,
   input  wire [31:0] wdata_i,
   input  wire        wr_i,
   input  wire        rd_i,
   output reg  [31:0] rdata_o,
   // Clock source ticks, one cycle each
   input  wire        xtal_tick_i,
   input  wire        osc_tick_i,
   input  wire        lprc_tick_i,
   input  wire        hse_tick_i,
   // Reference, timestamp and tamper pins
   input  wire        ref_i,
   input  wire        stamp_i,
   input  wire [2:0]  tamper_i,
   // Interrupt and wake
   output reg         irq_o
);
   // ==========================================
   // Reset release
   reg [1:0] rst_sync_reg;
   wire      rst_n = rst_sync_reg[1];
   always @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i) rst_sync_reg <= 2'b00;
      else         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   end

   // ==========================================
   // BCD helpers
   function [7:0] bcd_inc;
      input [7:0] v;
      begin
         if (v[3:0] == 4'h9) bcd_inc = {v[7:4] + 4'h1, 4'h0};
         else                bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
   endfunction

   function [7:0] month_len;
      input [7:0] m;
      input [7:0] y;
      reg         leap;
      begin
         leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                     : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
         case (m)
            8'h02: month_len = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
            default: month_len = 8'h31;
         endcase
      end
   endfunction

   // ==========================================
   // Registers
   reg [10:0] ctrl_reg;
   reg [23:0] time_reg;
   reg [26:0] date_reg;
   reg [31:0] alra_reg;
   reg [31:0] alrb_reg;
   reg [16:0] wut_reload_reg;
   reg [16:0] wut_cnt_reg;
   reg [14:0] shift_reg;
   reg [8:0]  cal_reg;
   reg [19:0] cal_win_reg;
   reg [23:0] ts_time_reg;
   reg [26:0] ts_date_reg;
   reg [6:0]  status_reg;
   reg [6:0]  mask_reg;
   reg [4:0]  tampcfg_reg;
   reg [14:0] presc_reg;
   reg [4:0]  hse_div_reg;
   reg        hse_tick_reg;
   reg        ref_d_reg;
   reg [5:0]  ref_cnt_reg;
   reg        stamp_d_reg;
   reg        sec_d_reg;
   reg [2:0]  tamp_cnt_reg [0:2];
   reg [2:0]  tamp_lvl_reg;
   reg [31:0] bkp_mem [0:15];

   wire wr_hit = wr_i;
   wire rd_stat = rd_i && (addr_i == `OFS_STATUS);

   // ==========================================
   // Clock source and pulse removal
   reg src_tick;
   always @*
   begin
      case (ctrl_reg[`CTL_CLKSEL])
         2'd0:    src_tick = xtal_tick_i;
         2'd1:    src_tick = osc_tick_i;
         2'd2:    src_tick = lprc_tick_i;
         default: src_tick = hse_tick_reg;
      endcase
   end

   wire cal_drop   = ({11'h000, cal_reg} > cal_win_reg);
   wire shift_drop = (shift_reg != 15'h0000);
   wire run_tick   = src_tick && ctrl_reg[`CTL_RUN];
   wire tick       = run_tick && !cal_drop && !shift_drop;

   // Reference second: realign the prescaler on each 50 or 60 reference edges
   wire ref_edge = ref_i && !ref_d_reg;
   wire [5:0] ref_top = ctrl_reg[`CTL_REF60] ? `REF_N60 : `REF_N50;
   wire ref_sec = ctrl_reg[`CTL_REFEN] && ref_edge && (ref_cnt_reg == ref_top);
   // A late second fires at the reference; an early one is only realigned
   wire sec_pulse = (tick && presc_reg == 15'h0000 && !ref_sec) ||
                    (ref_sec && presc_reg < {1'b0, PRESC[14:1]});

   // ==========================================
   // Next calendar value
   reg [23:0] time_next;
   reg [26:0] date_next;
   reg        day_roll;
   reg [7:0]  hr;
   reg [7:0]  hr_inc;
   always @*
   begin
      time_next = time_reg;
      date_next = date_reg;
      day_roll  = 1'b0;
      hr        = {2'b00, time_reg[21:16]};
      hr_inc    = bcd_inc(hr);
      if (time_reg[7:0] != 8'h59) time_next[7:0] = bcd_inc(time_reg[7:0]);
      else
      begin
         time_next[7:0] = 8'h00;
         if (time_reg[15:8] != 8'h59) time_next[15:8] = bcd_inc(time_reg[15:8]);
         else
         begin
            time_next[15:8] = 8'h00;
            if (ctrl_reg[`CTL_FMT12])
            begin
               if (hr == 8'h12) time_next[21:16] = 6'h01;
               else time_next[21:16] = hr_inc[5:0];
               if (hr == 8'h11)
               begin
                  time_next[22] = ~time_reg[22];
                  day_roll      = time_reg[22];
               end
            end
            else if (hr == 8'h23)
            begin
               time_next[22:16] = 7'h00;
               day_roll         = 1'b1;
            end
            else time_next[21:16] = hr_inc[5:0];
         end
      end
      if (day_roll)
      begin
         date_next[26:24] = (date_reg[26:24] == 3'd7) ? 3'd1 : date_reg[26:24] + 3'd1;
         if (date_reg[7:0] != month_len(date_reg[15:8], date_reg[23:16]))
            date_next[7:0] = bcd_inc(date_reg[7:0]);
         else
         begin
            date_next[7:0] = 8'h01;
            if (date_reg[15:8] != 8'h12) date_next[15:8] = bcd_inc(date_reg[15:8]);
            else
            begin
               date_next[15:8]  = 8'h01;
               date_next[23:16] = (date_reg[23:16] == 8'h99) ? 8'h00 : bcd_inc(date_reg[23:16]);
            end
         end
      end
   end

   // ==========================================
   // Events
   wire alra_hit = sec_d_reg && ctrl_reg[`CTL_ALRAEN] && (time_reg == alra_reg[23:0]) &&
                   (alra_reg[31:24] == 8'h00 || alra_reg[31:24] == date_reg[7:0]);
   wire alrb_hit = sec_d_reg && ctrl_reg[`CTL_ALRBEN] && (time_reg == alrb_reg[23:0]) &&
                   (alrb_reg[31:24] == 8'h00 || alrb_reg[31:24] == date_reg[7:0]);
   wire wut_hit  = tick && ctrl_reg[`CTL_WUTEN] && (wut_cnt_reg == 17'h0_0000);

   // Tamper filter: 0 takes a raw level, else 2^n - 1 equal samples on the clock ticks
   reg [2:0] tamp_new;
   reg [2:0] tamp_lvl_next;
   integer   i;
   integer   j;
   always @*
   begin
      for (i = 0; i < 3; i = i + 1)
      begin
         if (tampcfg_reg[1:0] == 2'd0)
            tamp_lvl_next[i] = tamper_i[i];
         else if (tamp_cnt_reg[i] == ((3'd1 << tampcfg_reg[1:0]) - 3'd1))
            tamp_lvl_next[i] = tamper_i[i];
         else
            tamp_lvl_next[i] = tamp_lvl_reg[i];
         tamp_new[i] = tamp_lvl_next[i] && !tamp_lvl_reg[i] && tampcfg_reg[2 + i];
      end
   end

   wire ts_hit = ctrl_reg[`CTL_TSEN] &&
                 ((stamp_i && !stamp_d_reg) || (ctrl_reg[`CTL_TAMPTS] && |tamp_new));
   wire [6:0] ev = {tamp_new, ts_hit, wut_hit, alrb_hit, alra_hit};

   // ==========================================
   // Main sequential logic
   always @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_reg       <= `RST_CTRL;
         time_reg       <= `RST_TIME;
         date_reg       <= `RST_DATE;
         alra_reg       <= 32'h0000_0000;
         alrb_reg       <= 32'h0000_0000;
         wut_reload_reg <= `RST_WUT;
         wut_cnt_reg    <= `RST_WUT;
         shift_reg      <= 15'h0000;
         cal_reg        <= 9'h000;
         cal_win_reg    <= 20'h0_0000;
         ts_time_reg    <= 24'h00_0000;
         ts_date_reg    <= 27'h000_0000;
         status_reg     <= 7'h00;
         mask_reg       <= 7'h00;
         tampcfg_reg    <= 5'h00;
         presc_reg      <= 15'h0000;
         hse_div_reg    <= 5'h00;
         hse_tick_reg   <= 1'b0;
         ref_d_reg      <= 1'b0;
         ref_cnt_reg    <= 6'h00;
         stamp_d_reg    <= 1'b0;
         sec_d_reg      <= 1'b0;
         tamp_lvl_reg   <= 3'b000;
         tamp_cnt_reg[0] <= 3'd0;
         tamp_cnt_reg[1] <= 3'd0;
         tamp_cnt_reg[2] <= 3'd0;
         irq_o          <= 1'b0;
         rdata_o        <= 32'h0000_0000;
      end
      else
      begin
         // High-speed clock divided by 32
         hse_div_reg  <= hse_div_reg + {4'h0, hse_tick_i};
         hse_tick_reg <= hse_tick_i && (hse_div_reg == `HSE_DIV);
         ref_d_reg    <= ref_i;
         stamp_d_reg  <= stamp_i;
         sec_d_reg    <= sec_pulse;
         tamp_lvl_reg <= tamp_lvl_next;
         for (j = 0; j < 3; j = j + 1)
         begin
            if (tamper_i[j] != tamp_lvl_reg[j] && src_tick)
               tamp_cnt_reg[j] <= tamp_cnt_reg[j] + 3'd1;
            else if (tamper_i[j] == tamp_lvl_reg[j])
               tamp_cnt_reg[j] <= 3'd0;
         end
         if (ref_edge)
            ref_cnt_reg <= (ref_cnt_reg == ref_top) ? 6'h00 : ref_cnt_reg + 6'h01;
         // Pulse removal bookkeeping
         if (run_tick)
            cal_win_reg <= (cal_win_reg == `CAL_WIN_MAX) ? 20'h0_0000 : cal_win_reg + 20'h0_0001;
         if (run_tick && shift_drop)
            shift_reg <= shift_reg - 15'h0001;
         // Prescaler, subsecond counter
         if (ref_sec || (tick && presc_reg == 15'h0000))
            presc_reg <= PRESC;
         else if (tick)
            presc_reg <= presc_reg - 15'h0001;
         if (sec_pulse)
         begin
            time_reg <= time_next;
            date_reg <= date_next;
         end
         // Wakeup counter
         if (tick && ctrl_reg[`CTL_WUTEN])
            wut_cnt_reg <= (wut_cnt_reg == 17'h0_0000) ? wut_reload_reg : wut_cnt_reg - 17'h0_0001;
         if (ts_hit)
         begin
            ts_time_reg <= time_reg;
            ts_date_reg <= date_reg;
         end
         // Set wins over the clearing read
         status_reg <= (rd_stat ? 7'h00 : status_reg) | ev;
         irq_o      <= |(((rd_stat ? 7'h00 : status_reg) | ev) & mask_reg);
         // Register writes
         if (wr_hit)
         begin
            case (addr_i)
               `OFS_CTRL:    ctrl_reg <= wdata_i[10:0];
               `OFS_TIME:
               begin
                  time_reg  <= wdata_i[23:0];
                  presc_reg <= PRESC;
               end
               `OFS_DATE:    date_reg <= wdata_i[26:0];
               `OFS_ALRA:    alra_reg <= wdata_i;
               `OFS_ALRB:    alrb_reg <= wdata_i;
               `OFS_WUT:
               begin
                  wut_reload_reg <= wdata_i[16:0];
                  wut_cnt_reg    <= wdata_i[16:0];
               end
               `OFS_SHIFT:   shift_reg <= wdata_i[14:0];
               `OFS_CAL:     cal_reg <= wdata_i[8:0];
               `OFS_MASK:    mask_reg <= wdata_i[6:0];
               `OFS_TAMPCFG: tampcfg_reg <= wdata_i[4:0];
               default: ;
            endcase
         end
         // Register reads, data in the following cycle
         if (rd_i)
         begin
            case (addr_i)
               `OFS_CTRL:    rdata_o <= {21'h00_0000, ctrl_reg};
               `OFS_TIME:    rdata_o <= {8'h00, time_reg};
               `OFS_DATE:    rdata_o <= {5'h00, date_reg};
               `OFS_SUBSEC:  rdata_o <= {17'h0_0000, presc_reg};
               `OFS_ALRA:    rdata_o <= alra_reg;
               `OFS_ALRB:    rdata_o <= alrb_reg;
               `OFS_WUT:     rdata_o <= {15'h0000, wut_cnt_reg};
               `OFS_SHIFT:   rdata_o <= {17'h0_0000, shift_reg};
               `OFS_CAL:     rdata_o <= {23'h00_0000, cal_reg};
               `OFS_TSTIME:  rdata_o <= {8'h00, ts_time_reg};
               `OFS_TSDATE:  rdata_o <= {5'h00, ts_date_reg};
               `OFS_STATUS:  rdata_o <= {25'h000_0000, status_reg};
               `OFS_MASK:    rdata_o <= {25'h000_0000, mask_reg};
               `OFS_TAMPCFG: rdata_o <= {27'h000_0000, tampcfg_reg};
               default:
                  if (addr_i[7:6] == 2'b01) rdata_o <= bkp_mem[addr_i[5:2]];
                  else rdata_o <= 32'h0000_0000;
            endcase
         end
         else
            rdata_o <= 32'h0000_0000;
      end
   end

   // ==========================================
   // Backup store: no reset so contents outlive any reset
   always @(posedge clock_i)
   begin
      if (wr_i && addr_i[7:6] == 2'b01)
         bkp_mem[addr_i[5:2]] <= wdata_i;
   end

endmodule // rtc_core
`default_nettype wire

/* hdl/rtc_regs.vh */
// Register offsets, field positions and reset values of the calendar clock
`ifndef RTC_REGS_VH
`define RTC_REGS_VH
// ==========================================
// Register byte offsets
`define OFS_CTRL     8'h00
`define OFS_TIME     8'h04
`define OFS_DATE     8'h08
`define OFS_SUBSEC   8'h0C
`define OFS_ALRA     8'h10
`define OFS_ALRB     8'h14
`define OFS_WUT      8'h18
`define OFS_SHIFT    8'h1C
`define OFS_CAL      8'h20
`define OFS_TSTIME   8'h24
`define OFS_TSDATE   8'h28
`define OFS_STATUS   8'h2C
`define OFS_MASK     8'h30
`define OFS_TAMPCFG  8'h34
`define OFS_BKP      8'h40
// ==========================================
// Control register fields
`define CTL_CLKSEL   1:0
`define CTL_FMT12    2
`define CTL_REFEN    3
`define CTL_REF60    4
`define CTL_ALRAEN   5
`define CTL_ALRBEN   6
`define CTL_WUTEN    7
`define CTL_TSEN     8
`define CTL_TAMPTS   9
`define CTL_RUN      10
// ==========================================
// Status and mask bits
`define ST_ALRA      0
`define ST_ALRB      1
`define ST_WUT       2
`define ST_TS        3
`define ST_TAMP      4
// ==========================================
// Reset values
`define RST_CTRL     11'h400
`define RST_TIME     24'h00_0000
`define RST_DATE     27'h100_0101
`define RST_WUT      17'h1_FFFF
// ==========================================
// Counts
`define HSE_DIV      5'h1F
`define CAL_WIN_MAX  20'hF_FFFF
`define REF_N50      6'h31
`define REF_N60      6'h3B
`endif

/* tb/rtc_core_checker.sv */
// Port checker for the calendar clock
`timescale 1ns/10ps
`default_nettype none
`include "rtc_regs.vh"
module rtc_core_checker #(
   parameter [14:0] PRESC = 15'h7FFF
) (
   // Clock, reset and register port
   input wire logic        clock_i,
   input wire logic        rstn_i,
   input wire logic [7:0]  addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [31:0] rdata_o,
   // Interrupt
   input wire logic        irq_o
);
   // ==========================================
   // Shadows and assertions
   logic [31:0] bk_sh [0:15];
   logic [15:0] bk_ok = 16'h0000;
   logic [31:0] bk_exp;
   logic [31:0] tim_sh;
   logic [10:0] ctl_sh;
   logic [6:0]  msk_sh;
   wire         bk = addr_i[7:6] == 2'b01 && addr_i[1:0] == 2'b00;
   wire         st_rd = rd_i && addr_i == `OFS_STATUS;
   wire         mk_wr = wr_i && addr_i == `OFS_MASK;
   // No reset here: the backup store keeps its words through every reset
   always @(posedge clock_i)
   begin
      if (wr_i && addr_i[7:6] == 2'b01)
      begin
         bk_sh[addr_i[5:2]] <= wdata_i;
         bk_ok[addr_i[5:2]] <= 1'b1;
      end
      bk_exp <= bk_sh[addr_i[5:2]];
      if (wr_i && addr_i == `OFS_TIME)
         tim_sh <= wdata_i;
   end
   always @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         ctl_sh <= `RST_CTRL;
         msk_sh <= 7'h00;
      end
      else
      begin
         if (wr_i && addr_i == `OFS_CTRL)
            ctl_sh <= wdata_i[10:0];
         if (mk_wr)
            msk_sh <= wdata_i[6:0];
      end
   end
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rstn_i);
   a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
      else $error("read data outside its slot");
   a_unmapped_zero: assert property (rd_i && (addr_i[7] || addr_i == 8'h38) |=> rdata_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_bkp_readback: assert property (rd_i && bk && bk_ok[addr_i[5:2]] |=> rdata_o == bk_exp)
      else $error("backup word read back wrong");
   a_ctrl_readback: assert property (rd_i && addr_i == `OFS_CTRL |=> rdata_o[10:0] == ctl_sh)
      else $error("control read back wrong");
   // A second needs PRESC+1 ticks, so a read two cycles after a write still shows it
   a_time_readback: assert property (wr_i && addr_i == `OFS_TIME && !ctl_sh[3] && PRESC >= 15'h0003
      ##2 rd_i && addr_i == `OFS_TIME |=> rdata_o[22:0] == tim_sh[22:0])
      else $error("time read back wrong");
   a_mask_quiet: assert property (msk_sh == 7'h00 && $past(msk_sh) == 7'h00 |-> !irq_o)
      else $error("interrupt while all masked");
   a_irq_sticky: assert property ($fell(irq_o) |-> $past(st_rd) || $past(mk_wr, 2))
      else $error("interrupt dropped without clear");
   a_release_quiet: assert property ($rose(rstn_i) |-> rdata_o == 32'h0000_0000 && !irq_o)
      else $error("outputs busy at reset release");
   c_status_irq: cover property (st_rd && irq_o);
   c_bkp_read: cover property (rd_i && bk && bk_ok[addr_i[5:2]]);
   c_irq_rise: cover property ($rose(irq_o));
endmodule // rtc_core_checker
bind rtc_core rtc_core_checker #(.PRESC(PRESC)) checker_i (
   .clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
`default_nettype wire

/* tb/rtc_src_model.sv */
// Clock source and pin model for the calendar clock
`timescale 1ns/10ps
`default_nettype none
module rtc_src_model (
   // Clock
   input  wire logic       clock_i,
   // Source pulses: crystal, oscillator, low-power RC, high-speed
   output var  logic [3:0] tick_o = 4'h0,
   // Reference, timestamp and tamper pins, idle low
   output var  logic       ref_o = 1'b0,
   output var  logic       stamp_o = 1'b0,
   output var  logic [2:0] tamper_o = 3'h0
);
   // ==========================================
   // Source pulses and pin events
   task automatic refs(input int n);
      int k;
      begin
         for (k = 0; k < n; k++)
         begin
            @(posedge clock_i);
            ref_o <= 1'b1;
            @(posedge clock_i);
            ref_o <= 1'b0;
         end
      end
   endtask
   task automatic ticks(input int n, input logic [1:0] s);
      int k;
      begin
         for (k = 0; k < n * (s == 2'h3 ? 32 : 1); k++)
         begin
            @(posedge clock_i);
            tick_o <= 4'h1 << s;
            @(posedge clock_i);
            tick_o <= 4'h0;
         end
      end
   endtask
   task automatic pins(input logic s, input logic [2:0] t);
      begin
         @(posedge clock_i);
         stamp_o <= s;
         tamper_o <= t;
         repeat (4) @(posedge clock_i);
         stamp_o <= 1'b0;
         tamper_o <= 3'h0;
      end
   endtask
endmodule // rtc_src_model
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the calendar clock
`timescale 1ns/10ps
`default_nettype none
`include "rtc_regs.vh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_top;
   // ==========================================
   // Signals, models and tasks
   logic        clock_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic [7:0]  addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0000_0000;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic [31:0] rdata_o;
   logic        irq_o;
   wire logic [3:0] tk;
   wire logic       rf;
   wire logic       st;
   wire logic [2:0] tp;
   int          mismatches = 0;
   int          num_checks = 0;
   int          i;
   logic [31:0] d_in [0:5] = '{32'h0104_0228, 32'h0101_0228, 32'h0104_0229,
                               32'h0101_0430, 32'h0701_1231, 32'h0101_0130};
   logic [31:0] d_out [0:5] = '{32'h0204_0229, 32'h0201_0301, 32'h0204_0301,
                                32'h0201_0501, 32'h0102_0101, 32'h0201_0131};
   always #5 clock_i = ~clock_i;
   rtc_core #(.PRESC(15'h0003)) rtc_core_i (
      .clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .xtal_tick_i(tk[0]), .osc_tick_i(tk[1]), .lprc_tick_i(tk[2]), .hse_tick_i(tk[3]),
      .ref_i(rf), .stamp_i(st), .tamper_i(tp), .irq_o(irq_o));
   rtc_src_model src (.clock_i(clock_i), .tick_o(tk), .ref_o(rf), .stamp_o(st), .tamper_o(tp));
   function automatic logic [31:0] pat(input int n);
      pat = {8'(n), 8'h5A, 8'(~n), 8'hC3};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      begin
         @(posedge clock_i);
         addr_i <= a;
         wdata_i <= d;
         wr_i <= 1'b1;
         @(posedge clock_i);
         wr_i <= 1'b0;
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
      begin
         @(posedge clock_i);
         addr_i <= a;
         rd_i <= 1'b1;
         @(posedge clock_i);
         rd_i <= 1'b0;
         @(posedge clock_i);
         `CHK(nm, e, rdata_o)
      end
   endtask
   task automatic wait_irq;
      int k;
      begin
         for (k = 0; k < 40 && irq_o !== 1'b1; k++)
            @(posedge clock_i);
         `CHK("irq raised", 1'b1, irq_o)
      end
   endtask
   task automatic do_reset;
      begin
         rstn_i <= 1'b0;
         repeat (16) @(posedge clock_i);
         rstn_i <= 1'b1;
         repeat (3) @(posedge clock_i);
      end
   endtask
   task automatic give_verdict;
      begin
         $display("checks %0d mismatches %0d", num_checks, mismatches);
         if (mismatches == 0 && num_checks > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   initial
   begin
      repeat (100000) @(posedge clock_i);
      mismatches++;
      give_verdict;
   end
   initial
   begin
      do_reset;
      rchk(`OFS_CTRL, 32'h0000_0400, "ctrl");
      rchk(`OFS_DATE, 32'h0100_0101, "date");
      wr(`OFS_TIME, 32'h0012_3456);
      rchk(`OFS_TIME, 32'h0012_3456, "time");
      wr(8'h38, 32'hFFFF_FFFF);
      rchk(8'h38, 32'h0000_0000, "unmapped");
      for (i = 0; i < 16; i++)
         wr(8'h40 + 8'(i * 4), pat(i));
      for (i = 0; i < 16; i++)
         rchk(8'h40 + 8'(i * 4), pat(i), "backup");
      do_reset;
      for (i = 0; i < 16; i++)
         rchk(8'h40 + 8'(i * 4), pat(i), "backup kept");
      $display("test registers done");
      for (i = 0; i < 6; i++)
      begin
         wr(`OFS_DATE, d_in[i]);
         wr(`OFS_TIME, 32'h0023_5959);
         src.ticks(4, 2'h0);
         rchk(`OFS_TIME, 32'h0000_0000, "midnight");
         rchk(`OFS_DATE, d_out[i], "next date");
      end
      $display("test calendar done");
      for (i = 0; i < 4; i++)
      begin
         wr(`OFS_CTRL, 32'h0000_0400 | 32'(i));
         wr(`OFS_TIME, 32'h0000_0000);
         src.ticks(3, i[1:0]);
         rchk(`OFS_TIME, 32'h0000_0000, "no second");
         src.ticks(1, i[1:0]);
         rchk(`OFS_TIME, 32'h0000_0001, "one second");
      end
      wr(`OFS_CTRL, 32'h0000_0400);
      wr(`OFS_TIME, 32'h0000_0000);
      wr(`OFS_SHIFT, 32'h0000_0002);
      src.ticks(5, 2'h0);
      rchk(`OFS_TIME, 32'h0000_0000, "shifted");
      src.ticks(1, 2'h0);
      rchk(`OFS_TIME, 32'h0000_0001, "after shift");
      rchk(`OFS_SHIFT, 32'h0000_0000, "shift used up");
      // Window count is still far below 511 here, so every pulse is dropped
      wr(`OFS_CAL, 32'h0000_01FF);
      wr(`OFS_TIME, 32'h0000_0000);
      src.ticks(4, 2'h0);
      rchk(`OFS_TIME, 32'h0000_0000, "calibrated");
      wr(`OFS_CAL, 32'h0000_0000);
      wr(`OFS_CTRL, 32'h0000_0408);
      wr(`OFS_TIME, 32'h0000_0000);
      src.ticks(3, 2'h0);
      src.refs(50);
      rchk(`OFS_TIME, 32'h0000_0001, "reference second");
      wr(`OFS_CTRL, 32'h0000_0404);
      wr(`OFS_TIME, 32'h0011_5959);
      src.ticks(4, 2'h0);
      rchk(`OFS_TIME, 32'h0052_0000, "noon pm");
      $display("test sources done");
      wr(`OFS_CTRL, 32'h0000_0420);
      wr(`OFS_MASK, 32'h0000_0001);
      wr(`OFS_TIME, 32'h0000_0000);
      wr(`OFS_ALRA, 32'h0000_0002);
      src.ticks(4, 2'h0);
      repeat (3) @(posedge clock_i);
      `CHK("early irq", 1'b0, irq_o)
      src.ticks(4, 2'h0);
      wait_irq;
      rchk(`OFS_STATUS, 32'h0000_0001, "alarm a");
      repeat (2) @(posedge clock_i);
      `CHK("irq cleared", 1'b0, irq_o)
      wr(`OFS_CTRL, 32'h0000_0440);
      wr(`OFS_MASK, 32'h0000_0000);
      wr(`OFS_ALRB, 32'h0000_0003);
      src.ticks(4, 2'h0);
      repeat (3) @(posedge clock_i);
      `CHK("masked irq", 1'b0, irq_o)
      rchk(`OFS_STATUS, 32'h0000_0002, "alarm b");
      wr(`OFS_CTRL, 32'h0000_0480);
      wr(`OFS_MASK, 32'h0000_0004);
      wr(`OFS_WUT, 32'h0000_0001);
      for (i = 0; i < 2; i++)
      begin
         src.ticks(4, 2'h0);
         wait_irq;
         rchk(`OFS_STATUS, 32'h0000_0004, "wakeup");
      end
      $display("test events done");
      wr(`OFS_CTRL, 32'h0000_0700);
      wr(`OFS_MASK, 32'h0000_0078);
      wr(`OFS_TAMPCFG, 32'h0000_001C);
      wr(`OFS_TIME, 32'h0012_3456);
      src.pins(1'b1, 3'h0);
      wait_irq;
      rchk(`OFS_TSTIME, 32'h0012_3456, "stamp time");
      rchk(`OFS_TSDATE, 32'h0201_0131, "stamp date");
      rchk(`OFS_STATUS, 32'h0000_0008, "stamp flag");
      for (i = 0; i < 3; i++)
      begin
         wr(`OFS_TIME, 32'h0001_0200 + 32'(i));
         src.pins(1'b0, 3'(1 << i));
         wait_irq;
         rchk(`OFS_TSTIME, 32'h0001_0200 + 32'(i), "tamper stamp");
         rchk(`OFS_STATUS, 32'h0000_0008 | 32'(16 << i), "tamper flag");
      end
      $display("test pins done");
      give_verdict;
   end
endmodule // tb_top
`default_nettype wire
